// ===== src/aolc_pkg.sv
// Constants and types for the output stage and link setup register bank
// Functional notes
// - Bit 2 picks zero, overrange, monitor, fast detect or sysref; reset 1.
// - Invert bit 2; format 00 offset binary, 01 twos; bit 0 swaps channels.
// - Four-bit lane rate range field; read-only lock flag in status bit 7.
// - Lane count is two to the power of quick setup bits 7:6; field resets to 1.
// - Converters are two to the power of quick setup bits 5:3; reset 1.
// - Octets per frame are two to the power of quick bits 2:0; reset 1.
package aolc_pkg;

  // ==========================================================================
  // Register indices and byte addresses (byte address is four times index)
  localparam int unsigned ADDR_W = 16;
  localparam logic [11:0] IDX_BIT2_SEL = 12'h55a;
  localparam logic [11:0] IDX_SAMPLE_FMT = 12'h561;
  localparam logic [11:0] IDX_CHAN_ORDER = 12'h564;
  localparam logic [11:0] IDX_RATE_RANGE = 12'h56e;
  localparam logic [11:0] IDX_LOCK_STATE = 12'h56f;
  localparam logic [11:0] IDX_QUICK_SETUP = 12'h570;
  localparam logic [15:0] ADDR_BIT2_SEL = {2'h0, IDX_BIT2_SEL, 2'h0};
  localparam logic [15:0] ADDR_SAMPLE_FMT = {2'h0, IDX_SAMPLE_FMT, 2'h0};
  localparam logic [15:0] ADDR_CHAN_ORDER = {2'h0, IDX_CHAN_ORDER, 2'h0};
  localparam logic [15:0] ADDR_RATE_RANGE = {2'h0, IDX_RATE_RANGE, 2'h0};
  localparam logic [15:0] ADDR_LOCK_STATE = {2'h0, IDX_LOCK_STATE, 2'h0};
  localparam logic [15:0] ADDR_QUICK_SETUP = {2'h0, IDX_QUICK_SETUP, 2'h0};

  // ==========================================================================
  // Reset values and writable bit masks
  localparam logic [7:0] RST_BIT2_SEL = 8'h01;
  localparam logic [7:0] RST_SAMPLE_FMT = 8'h01;
  localparam logic [7:0] RST_CHAN_ORDER = 8'h00;
  localparam logic [7:0] RST_RATE_RANGE = 8'h00;
  localparam logic [7:0] RST_LOCK_STATE = 8'h00;
  localparam logic [7:0] RST_QUICK_SETUP = 8'h49;
  localparam logic [7:0] WM_BIT2_SEL = 8'h07;
  localparam logic [7:0] WM_SAMPLE_FMT = 8'h07;
  localparam logic [7:0] WM_CHAN_ORDER = 8'h03;
  localparam logic [7:0] WM_RATE_RANGE = 8'hf0;
  localparam logic [7:0] WM_QUICK_SETUP = 8'hff;

  // ==========================================================================
  // Field positions
  localparam int unsigned SEL_HI = 2;
  localparam int unsigned INVERT_BIT = 2;
  localparam int unsigned FMT_HI = 1;
  localparam int unsigned SWAP_BIT = 0;
  localparam int unsigned RATE_HI = 7;
  localparam int unsigned RATE_LO = 4;
  localparam int unsigned LOCK_BIT = 7;
  localparam int unsigned LANES_HI = 7;
  localparam int unsigned LANES_LO = 6;
  localparam int unsigned CONV_HI = 5;
  localparam int unsigned CONV_LO = 3;
  localparam int unsigned OCT_HI = 2;
  localparam int unsigned OCT_LO = 0;

  // ==========================================================================
  // Codes, widths and bus answers
  localparam int unsigned SAMPLE_W = 14;
  typedef enum logic [2:0] {
    SEL_ZERO = 3'h0,
    SEL_OVERRANGE = 3'h1,
    SEL_SIG_MON = 3'h2,
    SEL_FAST_DET = 3'h3,
    SEL_SYSREF = 3'h5
  } aolc_sel_type;
  localparam logic [1:0] FMT_OFFSET = 2'h0;
  localparam logic [1:0] FMT_TWOS = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {WR_COLLECT, WR_RESP} aolc_wr_state_type;

endpackage

// ===== src/aolc_cfg_if.sv
// Interface between the register bank and the output stage
`timescale 1ns/100ps
interface aolc_cfg_if;
  logic [2:0] bit2_sel;
  logic invert;
  logic [1:0] fmt;
  logic swap;
  logic [7:0] quick;
  logic [3:0] flags;
  logic [aolc_pkg::SAMPLE_W-1:0] sample_a_raw;
  logic [aolc_pkg::SAMPLE_W-1:0] sample_b_raw;
  logic ctl_bit2;
  logic [aolc_pkg::SAMPLE_W-1:0] sample_a;
  logic [aolc_pkg::SAMPLE_W-1:0] sample_b;
  logic [3:0] lane_count;
  logic [7:0] conv_count;
  logic [7:0] octet_count;
  modport regs (output bit2_sel, invert, fmt, swap, quick, flags,
    sample_a_raw, sample_b_raw, input ctl_bit2, sample_a, sample_b,
    lane_count, conv_count, octet_count);
  modport stage (input bit2_sel, invert, fmt, swap, quick, flags,
    sample_a_raw, sample_b_raw, output ctl_bit2, sample_a, sample_b,
    lane_count, conv_count, octet_count);
endinterface

// ===== src/aolc_output_stage.sv
// Output stage: control bit 2 source, sample shaping and link counts
`timescale 1ns/100ps
module aolc_output_stage (
  input wire logic clock_in,
  input wire logic reset_in,
  aolc_cfg_if.stage cfg
);

  // ==========================================================================
  // Combinational selection
  logic next_ctl_bit2;
  logic [aolc_pkg::SAMPLE_W-1:0] ord_a;
  logic [aolc_pkg::SAMPLE_W-1:0] ord_b;
  logic [aolc_pkg::SAMPLE_W-1:0] inv_a;
  logic [aolc_pkg::SAMPLE_W-1:0] inv_b;
  logic [aolc_pkg::SAMPLE_W-1:0] fmt_mask;

  // Control bit 2 source; reserved codes drive zero
  always_comb begin
    case (cfg.bit2_sel)
      aolc_pkg::SEL_OVERRANGE: next_ctl_bit2 = cfg.flags[0];
      aolc_pkg::SEL_SIG_MON: next_ctl_bit2 = cfg.flags[1];
      aolc_pkg::SEL_FAST_DET: next_ctl_bit2 = cfg.flags[2];
      aolc_pkg::SEL_SYSREF: next_ctl_bit2 = cfg.flags[3];
      default: next_ctl_bit2 = 1'b0;
    endcase
  end

  // Swap, invert, then offset binary flips the sign bit
  assign ord_a = cfg.swap ? cfg.sample_b_raw : cfg.sample_a_raw;
  assign ord_b = cfg.swap ? cfg.sample_a_raw : cfg.sample_b_raw;
  assign inv_a = cfg.invert ? ~ord_a : ord_a;
  assign inv_b = cfg.invert ? ~ord_b : ord_b;
  assign fmt_mask = {(cfg.fmt == aolc_pkg::FMT_OFFSET),
    {(aolc_pkg::SAMPLE_W-1){1'b0}}};

  // Registered results
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cfg.ctl_bit2 <= 1'b0;
      cfg.sample_a <= '0;
      cfg.sample_b <= '0;
      cfg.lane_count <= 4'h1;
      cfg.conv_count <= 8'h01;
      cfg.octet_count <= 8'h01;
    end else begin
      cfg.ctl_bit2 <= next_ctl_bit2;
      cfg.sample_a <= inv_a ^ fmt_mask;
      cfg.sample_b <= inv_b ^ fmt_mask;
      cfg.lane_count <= 4'h1 <<
        cfg.quick[aolc_pkg::LANES_HI:aolc_pkg::LANES_LO];
      cfg.conv_count <= 8'h01 <<
        cfg.quick[aolc_pkg::CONV_HI:aolc_pkg::CONV_LO];
      cfg.octet_count <= 8'h01 <<
        cfg.quick[aolc_pkg::OCT_HI:aolc_pkg::OCT_LO];
    end
  end

endmodule // aolc_output_stage

// ===== src/aolc_regs.sv
// Output stage and link setup register bank with AXI4-Lite slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
module aolc_regs (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [15:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [15:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic overrange_in,
  input wire logic signal_monitor_flag_in,
  input wire logic fast_detect_flag_in,
  input wire logic sysref_in,
  input wire logic pll_lock_in,
  input wire logic [13:0] sample_a_in,
  input wire logic [13:0] sample_b_in,
  output logic control_bit2_out,
  output logic [13:0] sample_a_out,
  output logic [13:0] sample_b_out,
  output logic [3:0] lane_rate_range_out,
  output logic [3:0] lane_count_out,
  output logic [7:0] converter_count_out,
  output logic [7:0] octets_count_out
);

  // ==========================================================================
  // Registers
  logic [7:0] control_bit2_select;
  logic [7:0] output_sample_format;
  logic [7:0] output_channel_order;
  logic [7:0] serial_lane_rate_range;
  logic [7:0] serializer_lock_state;
  logic [7:0] link_quick_setup;
  aolc_pkg::aolc_wr_state_type wr_state;
  aolc_pkg::aolc_wr_state_type next_wr_state;
  logic have_aw;
  logic have_w;
  logic [15:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;

  // ==========================================================================
  // Output stage
  aolc_cfg_if cfg ();
  aolc_output_stage u_stage (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .cfg(cfg)
  );

  // Configuration fields to the output stage
  assign cfg.bit2_sel = control_bit2_select[aolc_pkg::SEL_HI:0];
  assign cfg.invert = output_sample_format[aolc_pkg::INVERT_BIT];
  assign cfg.fmt = output_sample_format[aolc_pkg::FMT_HI:0];
  assign cfg.swap = output_channel_order[aolc_pkg::SWAP_BIT];
  assign cfg.quick = link_quick_setup;
  assign cfg.flags = {sysref_in, fast_detect_flag_in,
    signal_monitor_flag_in, overrange_in};
  assign cfg.sample_a_raw = sample_a_in;
  assign cfg.sample_b_raw = sample_b_in;

  // Outputs, each held in a flip-flop
  assign control_bit2_out = cfg.ctl_bit2;
  assign sample_a_out = cfg.sample_a;
  assign sample_b_out = cfg.sample_b;
  assign lane_rate_range_out =
    serial_lane_rate_range[aolc_pkg::RATE_HI:aolc_pkg::RATE_LO];
  assign lane_count_out = cfg.lane_count;
  assign converter_count_out = cfg.conv_count;
  assign octets_count_out = cfg.octet_count;

  // ==========================================================================
  // Write channel handshakes and decode
  logic aw_fire;
  logic w_fire;
  logic b_fire;
  logic wr_go;
  logic next_have_aw;
  logic next_have_w;
  logic we_sel;
  logic we_fmt;
  logic we_order;
  logic we_rate;
  logic wr_hit;

  assign aw_fire = awvalid_in && awready_out;
  assign w_fire = wvalid_in && wready_out;
  assign b_fire = bvalid_out && bready_in;
  assign wr_go = (wr_state == aolc_pkg::WR_COLLECT) && have_aw && have_w;
  assign next_have_aw = !wr_go && (have_aw || aw_fire);
  assign next_have_w = !wr_go && (have_w || w_fire);

  // Write address decode; the lock state register takes no writes
  always_comb begin
    we_sel = 1'b0;
    we_fmt = 1'b0;
    we_order = 1'b0;
    we_rate = 1'b0;
    wr_hit = 1'b1;
    if (wr_addr == aolc_pkg::ADDR_BIT2_SEL) begin
      we_sel = 1'b1;
    end else if (wr_addr == aolc_pkg::ADDR_SAMPLE_FMT) begin
      we_fmt = 1'b1;
    end else if (wr_addr == aolc_pkg::ADDR_CHAN_ORDER) begin
      we_order = 1'b1;
    end else if (wr_addr == aolc_pkg::ADDR_RATE_RANGE) begin
      we_rate = 1'b1;
    end else if (wr_addr == aolc_pkg::ADDR_LOCK_STATE) begin
      wr_hit = 1'b1;
    end else if (wr_addr != aolc_pkg::ADDR_QUICK_SETUP) begin
      wr_hit = 1'b0;
    end
  end

  logic we_quick;
  logic do_write;
  assign we_quick = (wr_addr == aolc_pkg::ADDR_QUICK_SETUP);
  assign do_write = wr_go && wr_lane0;

  // Write state
  always_comb begin
    next_wr_state = wr_state;
    case (wr_state)
      aolc_pkg::WR_COLLECT: if (wr_go) next_wr_state = aolc_pkg::WR_RESP;
      aolc_pkg::WR_RESP: if (b_fire) next_wr_state = aolc_pkg::WR_COLLECT;
      default: next_wr_state = aolc_pkg::WR_COLLECT;
    endcase
  end

  // Write channel flops
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wr_state <= aolc_pkg::WR_COLLECT;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= aolc_pkg::RESP_OKAY;
      wr_addr <= '0;
      wr_byte <= '0;
      wr_lane0 <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      have_aw <= next_have_aw;
      have_w <= next_have_w;
      awready_out <= (next_wr_state == aolc_pkg::WR_COLLECT) && !next_have_aw;
      wready_out <= (next_wr_state == aolc_pkg::WR_COLLECT) && !next_have_w;
      if (aw_fire) wr_addr <= awaddr_in;
      if (w_fire) wr_byte <= wdata_in[7:0];
      if (w_fire) wr_lane0 <= wstrb_in[0];
      if (wr_go) bvalid_out <= 1'b1;
      else if (b_fire) bvalid_out <= 1'b0;
      if (wr_go) bresp_out <= wr_hit ? aolc_pkg::RESP_OKAY
                                     : aolc_pkg::RESP_SLVERR;
    end
  end

  // ==========================================================================
  // Register storage; writes change only writable bits, the lock bit tracks pll_lock_in
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      control_bit2_select <= aolc_pkg::RST_BIT2_SEL;
      output_sample_format <= aolc_pkg::RST_SAMPLE_FMT;
      output_channel_order <= aolc_pkg::RST_CHAN_ORDER;
      serial_lane_rate_range <= aolc_pkg::RST_RATE_RANGE;
      serializer_lock_state <= aolc_pkg::RST_LOCK_STATE;
      link_quick_setup <= aolc_pkg::RST_QUICK_SETUP;
    end else begin
      if (do_write && we_sel) control_bit2_select <=
        wr_byte & aolc_pkg::WM_BIT2_SEL;
      if (do_write && we_fmt) output_sample_format <=
        wr_byte & aolc_pkg::WM_SAMPLE_FMT;
      if (do_write && we_order) output_channel_order <=
        wr_byte & aolc_pkg::WM_CHAN_ORDER;
      if (do_write && we_rate) serial_lane_rate_range <=
        wr_byte & aolc_pkg::WM_RATE_RANGE;
      if (do_write && we_quick) link_quick_setup <=
        wr_byte & aolc_pkg::WM_QUICK_SETUP;
      serializer_lock_state <= {pll_lock_in, 7'h00};
    end
  end

  // ==========================================================================
  // Read channel
  logic ar_fire;
  logic r_fire;
  logic [7:0] rd_byte;
  logic rd_hit;
  assign ar_fire = arvalid_in && arready_out;
  assign r_fire = rvalid_out && rready_in;

  // Read address decode
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (araddr_in == aolc_pkg::ADDR_BIT2_SEL) begin
      rd_byte = control_bit2_select;
    end else if (araddr_in == aolc_pkg::ADDR_SAMPLE_FMT) begin
      rd_byte = output_sample_format;
    end else if (araddr_in == aolc_pkg::ADDR_CHAN_ORDER) begin
      rd_byte = output_channel_order;
    end else if (araddr_in == aolc_pkg::ADDR_RATE_RANGE) begin
      rd_byte = serial_lane_rate_range;
    end else if (araddr_in == aolc_pkg::ADDR_LOCK_STATE) begin
      rd_byte = serializer_lock_state;
    end else if (araddr_in == aolc_pkg::ADDR_QUICK_SETUP) begin
      rd_byte = link_quick_setup;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel flops; one read under way at a time
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= '0;
      rresp_out <= aolc_pkg::RESP_OKAY;
    end else begin
      arready_out <= !(rvalid_out && !r_fire) && !ar_fire;
      if (ar_fire) begin
        rvalid_out <= 1'b1;
        rdata_out <= {24'h000000, rd_byte};
        rresp_out <= rd_hit ? aolc_pkg::RESP_OKAY : aolc_pkg::RESP_SLVERR;
      end else if (r_fire) begin
        rvalid_out <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Assertions
  property p_sel_sysref;
    @(posedge clock_in) disable iff (reset_in)
    (control_bit2_select[2:0] == aolc_pkg::SEL_SYSREF)
      |=> (control_bit2_out == $past(sysref_in));
  endproperty
  a_sel_sysref: assert property (p_sel_sysref)
    else $error("control bit 2 does not follow sysref");

  property p_sel_reserved;
    @(posedge clock_in) disable iff (reset_in)
    (control_bit2_select[2:0] == 3'h4 || control_bit2_select[2:1] == 2'h3)
      |=> !control_bit2_out;
  endproperty
  a_sel_reserved: assert property (p_sel_reserved)
    else $error("reserved selector code drives a one");

  property p_offset_binary;
    @(posedge clock_in) disable iff (reset_in)
    (output_sample_format[2:0] == 3'h0 && !output_channel_order[0])
      |=> (sample_a_out == {~$past(sample_a_in[13]),
        $past(sample_a_in[12:0])});
  endproperty
  a_offset_binary: assert property (p_offset_binary)
    else $error("offset binary sample is wrong");

  property p_swap_invert;
    @(posedge clock_in) disable iff (reset_in)
    (output_sample_format[2:0] == 3'h5 && output_channel_order[0])
      |=> (sample_a_out == ~$past(sample_b_in));
  endproperty
  a_swap_invert: assert property (p_swap_invert)
    else $error("swapped inverted sample is wrong");

  property p_rate_write;
    @(posedge clock_in) disable iff (reset_in)
    (do_write && we_rate) |=> (lane_rate_range_out == $past(wr_byte[7:4]))
      ##1 $stable(lane_rate_range_out);
  endproperty
  a_rate_write: assert property (p_rate_write)
    else $error("lane rate range not stored");

  property p_lock_read;
    @(posedge clock_in) disable iff (reset_in)
    (ar_fire && araddr_in == aolc_pkg::ADDR_LOCK_STATE)
      ##0 $stable(pll_lock_in) ##1 $stable(pll_lock_in)
      |-> (rdata_out == {24'h0, pll_lock_in, 7'h0});
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("lock status read is wrong");

  property p_lane_count;
    @(posedge clock_in) disable iff (reset_in)
    !reset_in |=> (lane_count_out == (4'h1 << $past(link_quick_setup[7:6])));
  endproperty
  a_lane_count: assert property (p_lane_count)
    else $error("lane count wrong");

  property p_conv_count;
    @(posedge clock_in) disable iff (reset_in)
    $changed(link_quick_setup) |=>
      (converter_count_out == (8'h01 << $past(link_quick_setup[5:3])));
  endproperty
  a_conv_count: assert property (p_conv_count)
    else $error("converter count wrong");

  property p_octet_count;
    @(posedge clock_in) disable iff (reset_in)
    (link_quick_setup[2:0] == 3'h3) [*2] |-> (octets_count_out == 8'h08);
  endproperty
  a_octet_count: assert property (p_octet_count)
    else $error("octet count wrong");

  c_write_done: cover property (@(posedge clock_in) disable iff (reset_in)
    b_fire && bresp_out == aolc_pkg::RESP_OKAY);
  c_read_done: cover property (@(posedge clock_in) disable iff (reset_in)
    r_fire && rresp_out == aolc_pkg::RESP_OKAY);
  c_swap_on: cover property (@(posedge clock_in) disable iff (reset_in)
    output_channel_order[0] && link_quick_setup[7:6] == 2'h1);

endmodule // aolc_regs

// ===== verif/testbench.sv
// Self-checking bench for the output stage and link setup register bank
`timescale 1ns/100ps
module testbench;
  // ==========================================================================
  // Clock, reset and design inputs
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] flags = 4'h0;
  logic pll_lock = 1'b0;
  logic [13:0] samp_a = 14'h0, samp_b = 14'h0;
  wire logic awready, wready, bvalid, arready, rvalid, ctl_bit2;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [13:0] out_a, out_b;
  wire logic [3:0] rate_out, lanes_out;
  wire logic [7:0] conv_out, oct_out;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [15:0] addrs [6];
  logic [7:0] rstv [6];
  logic [7:0] msk [6];
  logic [3:0] rcodes [4];
  logic [7:0] qvals [5];
  logic [27:0] exp_s;
  logic exp_b;

  // Half period of 20 ns gives 25 MHz
  always #20 clock_in = ~clock_in;

  aolc_regs dut_u (.clock_in(clock_in), .reset_in(reset_in),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
    .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(rready), .overrange_in(flags[0]),
    .signal_monitor_flag_in(flags[1]), .fast_detect_flag_in(flags[2]),
    .sysref_in(flags[3]), .pll_lock_in(pll_lock), .sample_a_in(samp_a),
    .sample_b_in(samp_b), .control_bit2_out(ctl_bit2),
    .sample_a_out(out_a), .sample_b_out(out_b),
    .lane_rate_range_out(rate_out), .lane_count_out(lanes_out),
    .converter_count_out(conv_out), .octets_count_out(oct_out));

  // ==========================================================================
  // Bus tasks and comparison
  task automatic axi_write(input logic [15:0] a, input logic [7:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    logic aw_done, w_done;
    @(posedge clock_in);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    r = 2'h3;
    while (1'b1) begin
      @(posedge clock_in);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic ar_done;
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_done = 1'b0;
    d = 32'hdead_beef;
    r = 2'h3;
    while (1'b1) begin
      @(posedge clock_in);
      if (!ar_done && arready === 1'b1) begin
        ar_done = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Let registered datapath outputs follow the inputs of the last edge
  task automatic settle();
    @(posedge clock_in);
    @(posedge clock_in);
    #1;
  endtask

  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    #(40 * 20000);
    errors++;
    finish_test();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    addrs = '{aolc_pkg::ADDR_BIT2_SEL, aolc_pkg::ADDR_SAMPLE_FMT,
      aolc_pkg::ADDR_CHAN_ORDER, aolc_pkg::ADDR_RATE_RANGE,
      aolc_pkg::ADDR_LOCK_STATE, aolc_pkg::ADDR_QUICK_SETUP};
    rstv = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h49};
    msk = '{8'h07, 8'h07, 8'h03, 8'hf0, 8'h00, 8'hff};
    rcodes = '{4'h0, 4'h1, 4'h3, 4'h5};
    qvals = '{8'h00, 8'h49, 8'h92, 8'h4b, 8'hff};
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    // Reset values, then writable and read-only bits
    for (int i = 0; i < 6; i++) begin
      axi_read(addrs[i], rd, rsp);
      chk({rsp, rd}, {2'h0, 24'h0, rstv[i]});
      axi_write(addrs[i], 8'hff, 4'hf, rsp);
      chk(rsp, 2'h0);
      axi_read(addrs[i], rd, rsp);
      chk(rd, {24'h0, msk[i]});
    end
    // Strobe off leaves the register alone
    axi_write(aolc_pkg::ADDR_QUICK_SETUP, 8'h00, 4'h0, rsp);
    axi_read(aolc_pkg::ADDR_QUICK_SETUP, rd, rsp);
    chk(rd, 32'h0000_00ff);
    // Unmapped and unaligned places answer with an error and zero data
    axi_read(16'h0000, rd, rsp);
    chk({rsp, rd}, {2'h2, 32'h0});
    axi_read(aolc_pkg::ADDR_QUICK_SETUP + 16'h1, rd, rsp);
    chk({rsp, rd}, {2'h2, 32'h0});
    axi_write(16'h0000, 8'h55, 4'hf, rsp);
    chk(rsp, 2'h2);
    // Control bit 2 source for every selector code
    for (int c = 0; c < 8; c++) begin
      axi_write(aolc_pkg::ADDR_BIT2_SEL, 8'(c), 4'hf, rsp);
      for (int p = 0; p < 2; p++) begin
        @(posedge clock_in);
        flags <= p ? 4'b1010 : 4'b0101;
        settle();
        case (c)
          1: exp_b = p ? 1'b0 : 1'b1;
          2: exp_b = p ? 1'b1 : 1'b0;
          3: exp_b = p ? 1'b0 : 1'b1;
          5: exp_b = p ? 1'b1 : 1'b0;
          default: exp_b = 1'b0;
        endcase
        chk(ctl_bit2, exp_b);
      end
    end
    // Sample invert, format and channel swap in every combination
    for (int f = 0; f < 8; f++) begin
      axi_write(aolc_pkg::ADDR_SAMPLE_FMT, 8'(f), 4'hf, rsp);
      for (int s = 0; s < 2; s++) begin
        axi_write(aolc_pkg::ADDR_CHAN_ORDER, 8'(s), 4'hf, rsp);
        samp_a <= 14'h0123 + 14'(f);
        samp_b <= 14'h2abc;
        settle();
        exp_s = s ? {samp_b, samp_a} : {samp_a, samp_b};
        if (f[2]) exp_s = ~exp_s;
        if (f[1:0] == 2'h0) exp_s = exp_s ^ {1'b1, 13'h0, 1'b1, 13'h0};
        chk({out_a, out_b}, exp_s);
      end
    end
    // Lane rate range codes
    for (int i = 0; i < 4; i++) begin
      axi_write(aolc_pkg::ADDR_RATE_RANGE, {rcodes[i], 4'hf}, 4'hf, rsp);
      axi_read(aolc_pkg::ADDR_RATE_RANGE, rd, rsp);
      chk(rd, {24'h0, rcodes[i], 4'h0});
      settle();
      chk(rate_out, rcodes[i]);
    end
    // Lock bit follows the PLL and ignores writes
    for (int p = 0; p < 2; p++) begin
      pll_lock <= p[0];
      settle();
      axi_write(aolc_pkg::ADDR_LOCK_STATE, 8'h7f, 4'hf, rsp);
      chk(rsp, 2'h0);
      axi_read(aolc_pkg::ADDR_LOCK_STATE, rd, rsp);
      chk(rd, {24'h0, p[0], 7'h0});
    end
    // Quick setup counts are powers of two of each field
    for (int i = 0; i < 5; i++) begin
      axi_write(aolc_pkg::ADDR_QUICK_SETUP, qvals[i], 4'hf, rsp);
      settle();
      chk(lanes_out, 4'h1 << qvals[i][7:6]);
      chk(conv_out, 8'h01 << qvals[i][5:3]);
      chk(oct_out, 8'h01 << qvals[i][2:0]);
    end
    finish_test();
  end
endmodule // testbench
